/* File: hw/flash_seq_params.svh */
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH

// register byte offsets
`define FS_OFF_CTRL      8'h00
`define FS_OFF_STAT      8'h04
`define FS_OFF_BOOT      8'h08
`define FS_OFF_LOCK      8'h0C

// control register bit positions
`define FS_BIT_EN        0
`define FS_BIT_BUSY      6
`define FS_CODE_W        5

// legal five-bit command codes
`define FS_CODE_NONE     5'h00
`define FS_CODE_FILL     5'h01
`define FS_CODE_ERASE    5'h03
`define FS_CODE_WRITE    5'h05
`define FS_CODE_LOCK     5'h09
`define FS_CODE_REEN     5'h11

// arm window after a control write, in clock cycles
`define FS_ARM_CYCLES    3'h4

// boot region starts, selected by the two size fuses
`define FS_BOOT_256      14'h3F00
`define FS_BOOT_512      14'h3E00
`define FS_BOOT_1024     14'h3C00
`define FS_BOOT_2048     14'h3800

// region split and address fields
`define FS_BLOCK_START   14'h3800
`define FS_CONC_PAGES    8'hE0
`define FS_PC_W          14
`define FS_PAGE_WORDS    64
`define FS_LOCK_RESET    6'h3F

// timing: clock, calibrated RC period, programming time
`define FS_CLK_PERIOD_NS 10
`define FS_RC_PERIOD_NS  1000
`define FS_OP_MIN_US     3700
`define FS_OP_MAX_US     4500
`define FS_OP_TIME_US    4000

// bus answers
`define FS_RESP_OKAY     2'h0
`define FS_RESP_SLVERR   2'h2

`endif

/* File: hw/flash_seq_pkg.sv */
package flash_seq_pkg;
  typedef enum logic [2:0] {
    CMD_NONE, CMD_FILL, CMD_ERASE, CMD_WRITE, CMD_LOCK, CMD_REEN
  } cmd_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_BUSY} seq_state_t;
endpackage

/* File: hw/op_timer_if.sv */
`timescale 1ns/1ps
interface op_timer_if;
  logic start;
  logic busy;
  logic done;
  modport ctl (output start, input busy, input done);
  modport tmr (input start, output busy, output done);
endinterface

/* File: hw/op_timer.sv */
`timescale 1ns/1ps
`include "flash_seq_params.svh"
module op_timer #(
  parameter int TICK_DIV = `FS_RC_PERIOD_NS / `FS_CLK_PERIOD_NS,
  parameter int OP_TICKS = `FS_OP_TIME_US * 1000 / `FS_RC_PERIOD_NS
) (
  input wire logic  aclk,
  input wire logic  rst,
  op_timer_if.tmr   tif
);
  logic [15:0] div_ff;
  logic [15:0] ticks_ff;
  logic        busy_ff;
  logic        done_ff;
  logic        rc_tick;

  // enable pulse standing in for the calibrated rc oscillator
  assign rc_tick = (div_ff == 16'(TICK_DIV - 1));
  assign tif.busy = busy_ff;
  assign tif.done = done_ff;

  always_ff @(posedge aclk) begin
    if (rst || tif.start || rc_tick) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= div_ff + 16'h0001;
    end
  end

  // duration counts rc ticks only, never cpu cycles
  always_ff @(posedge aclk) begin
    if (rst) begin
      busy_ff  <= 1'b0;
      done_ff  <= 1'b0;
      ticks_ff <= 16'h0000;
    end else begin
      done_ff <= 1'b0;
      if (tif.start && !busy_ff) begin
        busy_ff  <= 1'b1;
        ticks_ff <= 16'h0000;
      end else if (busy_ff && rc_tick) begin
        if (ticks_ff == 16'(OP_TICKS - 1)) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end else begin
          ticks_ff <= ticks_ff + 16'h0001;
        end
      end
    end
  end
endmodule // op_timer

/* File: hw/flash_self_program_sequencer.sv */
// What this block does
// - a reset during erase or write lets it finish while supply stays good
// - every program operation is timed from the calibrated rc tick
// - erase, write and lock write each stay busy 3.7 ms to 4.5 ms
// - two size fuses pick boot region start; boot reset address equals it
// - words below 0x3800 are concurrent-read region, above are blocking
// - flash word address is a 14-bit program counter value
// - a page holds 64 words, word position is pc bits 5:0
// - erase and write take page from z bits 14:7
// - z bits 6:1 pick buffer word on fill; zero on page write
// - z bit 0 is zero for store commands and is ignored
// - during erase or write only the blocking region may be fetched
// - control write arms the store for four cycles, then self-clears
// - program to concurrent region sets busy flag; re-enable or fill clears
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "flash_seq_params.svh"
module flash_self_program_sequencer
  import flash_seq_pkg::*;
#(
  parameter int TICK_DIV = `FS_RC_PERIOD_NS / `FS_CLK_PERIOD_NS,
  parameter int OP_TICKS = `FS_OP_TIME_US * 1000 / `FS_RC_PERIOD_NS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        supply_good,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        boot_size_fuse_hi,
  input  wire logic        boot_size_fuse_lo,
  input  wire logic        eeprom_write_busy_bit,
  input  wire logic        store_strobe,
  input  wire logic [15:0] z_pointer,
  input  wire logic [15:0] store_data,
  input  wire logic [13:0] fetch_addr,
  output logic             fetch_allowed,
  output logic             cpu_halt,
  output logic [13:0]      boot_start_addr,
  output logic             flash_erase,
  output logic             flash_write,
  output logic [7:0]       flash_page,
  input  wire logic [5:0]  buf_rd_index,
  output logic [15:0]      buf_rd_data,
  output logic [5:0]       lock_bits
);
  localparam int WORDS = `FS_PAGE_WORDS;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic in_blocking_region(input logic [`FS_PC_W-1:0] a);
    in_blocking_region = (a >= `FS_BLOCK_START);
  endfunction

  function automatic cmd_t decode_code(input logic [`FS_CODE_W-1:0] c);
    case (c)
      `FS_CODE_FILL:  decode_code = CMD_FILL;
      `FS_CODE_ERASE: decode_code = CMD_ERASE;
      `FS_CODE_WRITE: decode_code = CMD_WRITE;
      `FS_CODE_LOCK:  decode_code = CMD_LOCK;
      `FS_CODE_REEN:  decode_code = CMD_REEN;
      default:        decode_code = CMD_NONE;
    endcase
  endfunction

  function automatic logic [`FS_CODE_W-1:0] encode_cmd(input cmd_t c);
    case (c)
      CMD_FILL:  encode_cmd = `FS_CODE_FILL;
      CMD_ERASE: encode_cmd = `FS_CODE_ERASE;
      CMD_WRITE: encode_cmd = `FS_CODE_WRITE;
      CMD_LOCK:  encode_cmd = `FS_CODE_LOCK;
      CMD_REEN:  encode_cmd = `FS_CODE_REEN;
      default:   encode_cmd = `FS_CODE_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  seq_state_t        st_ff;
  cmd_t              cmd_ff;
  logic [2:0]        arm_cnt_ff;
  logic [7:0]        page_ff;
  logic              halt_ff;
  logic [5:0]        lock_data_ff;
  logic [5:0]        lock_ff;
  logic              region_busy_ff;
  logic [WORDS-1:0]  filled_ff;
  logic [15:0]       buf_ff [WORDS];
  logic              fetch_ok_ff;
  logic [13:0]       boot_ff;
  logic [15:0]       buf_rd_ff;

  logic              aw_got_ff, w_got_ff, awready_ff, wready_ff, bvalid_ff;
  logic [7:0]        awaddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic [1:0]        bresp_ff;
  logic              arready_ff, rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;

  logic              nxt_aw_got, nxt_w_got, do_write, ctrl_wr, eng_rst;
  logic              store_go, fill_go, reen_go, prog_go;
  cmd_t              wr_cmd;
  logic [31:0]       nxt_rdata;
  logic              nxt_rerr;

  op_timer_if tif ();

  op_timer #(.TICK_DIV(TICK_DIV), .OP_TICKS(OP_TICKS)) u_timer (
    .aclk (aclk),
    .rst  (eng_rst),
    .tif  (tif.tmr)
  );

  // the engine ignores a system reset while a flash operation runs
  assign eng_rst = !supply_good || (!aresetn && (st_ff != ST_BUSY));

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write side
  assign do_write   = aw_got_ff && w_got_ff && !bvalid_ff;
  assign nxt_aw_got = (aw_got_ff && !do_write) || (s_axi_awvalid && awready_ff);
  assign nxt_w_got  = (w_got_ff && !do_write) || (s_axi_wvalid && wready_ff);
  assign ctrl_wr    = do_write && (awaddr_ff == `FS_OFF_CTRL) && wstrb_ff[0];
  assign wr_cmd     = decode_code(wdata_ff[`FS_CODE_W-1:0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else begin
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      awready_ff <= !nxt_aw_got;
      wready_ff  <= !nxt_w_got;
      if (s_axi_awvalid && awready_ff) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `FS_RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      // only the control register is writable; the rest answer with an error
      bresp_ff  <= (awaddr_ff == `FS_OFF_CTRL) ? `FS_RESP_OKAY : `FS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read side
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rerr  = 1'b0;
    case (s_axi_araddr)
      `FS_OFF_CTRL: begin
        nxt_rdata[`FS_CODE_W-1:0] = (st_ff == ST_IDLE) ? `FS_CODE_NONE : encode_cmd(cmd_ff);
        nxt_rdata[`FS_BIT_BUSY]   = region_busy_ff;
      end
      `FS_OFF_STAT: nxt_rdata[3:0] = {eeprom_write_busy_bit, boot_size_fuse_hi,
                                      boot_size_fuse_lo, tif.busy};
      `FS_OFF_BOOT: nxt_rdata[13:0] = boot_ff;
      `FS_OFF_LOCK: nxt_rdata[5:0]  = lock_ff;
      default:      nxt_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= `FS_RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rerr ? `FS_RESP_SLVERR : `FS_RESP_OKAY;
    end else if (rvalid_ff && s_axi_rready) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequencing
  // store enable stays set while armed or busy, which is what software polls
  // before a new command; an eeprom write also refuses the control write
  // a control write in the same cycle wins, so the timer never starts unowned
  assign store_go = (st_ff == ST_ARMED) && store_strobe && !ctrl_wr;
  assign fill_go  = store_go && (cmd_ff == CMD_FILL);
  assign reen_go  = store_go && (cmd_ff == CMD_REEN);
  assign prog_go  = store_go && (cmd_ff inside {CMD_ERASE, CMD_WRITE, CMD_LOCK});
  assign tif.start = prog_go;

  always_ff @(posedge aclk) begin
    if (eng_rst) begin
      st_ff        <= ST_IDLE;
      cmd_ff       <= CMD_NONE;
      arm_cnt_ff   <= 3'h0;
      page_ff      <= 8'h00;
      halt_ff      <= 1'b0;
      lock_data_ff <= 6'h00;
    end else begin
      case (st_ff)
        ST_IDLE, ST_ARMED: begin
          if (ctrl_wr && !eeprom_write_busy_bit && (wr_cmd != CMD_NONE)) begin
            st_ff      <= ST_ARMED;
            cmd_ff     <= wr_cmd;
            arm_cnt_ff <= `FS_ARM_CYCLES;
          end else if (prog_go) begin
            st_ff        <= ST_BUSY;
            page_ff      <= z_pointer[14:7];
            lock_data_ff <= store_data[5:0];
            // a blocking-region target stalls the cpu for the whole operation
            halt_ff      <= (cmd_ff != CMD_LOCK) &&
                            in_blocking_region({z_pointer[14:7], 6'h00});
          end else if (store_go) begin
            st_ff  <= ST_IDLE;
            cmd_ff <= CMD_NONE;
          end else if (st_ff == ST_ARMED) begin
            arm_cnt_ff <= arm_cnt_ff - 3'h1;
            if (arm_cnt_ff == 3'h1) begin
              st_ff  <= ST_IDLE;
              cmd_ff <= CMD_NONE;
            end
          end
        end
        ST_BUSY: begin
          if (tif.done) begin
            st_ff   <= ST_IDLE;
            cmd_ff  <= CMD_NONE;
            halt_ff <= 1'b0;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // lock bits only move toward programmed (zero) and survive bus reset
  always_ff @(posedge aclk) begin
    if (!supply_good) begin
      lock_ff <= `FS_LOCK_RESET;
    end else if (tif.done && (cmd_ff == CMD_LOCK) && (st_ff == ST_BUSY)) begin
      lock_ff <= lock_ff & lock_data_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      region_busy_ff <= 1'b0;
    end else if (prog_go && (cmd_ff != CMD_LOCK) && (z_pointer[14:7] < `FS_CONC_PAGES)) begin
      region_busy_ff <= 1'b1;
    end else if (reen_go || fill_go) begin
      region_busy_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // temporary page buffer
  // each word takes one load until the buffer is erased by a page write,
  // a re-enable command or reset; a re-enable write aborts a half load
  always_ff @(posedge aclk) begin
    if (!aresetn || reen_go || (ctrl_wr && (wr_cmd == CMD_REEN))) begin
      filled_ff <= '0;
    end else if (tif.done && (cmd_ff == CMD_WRITE) && (st_ff == ST_BUSY)) begin
      filled_ff <= '0;
    end else if (fill_go) begin
      filled_ff[z_pointer[6:1]] <= 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi++) begin : g_buf
      always_ff @(posedge aclk) begin
        if (fill_go && (z_pointer[6:1] == 6'(gi)) && !filled_ff[gi]) begin
          buf_ff[gi] <= store_data;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // fetch gating, boot region, flash side outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_ok_ff <= 1'b1;
    end else begin
      // concurrent region is unreadable while its flag is set or a page op runs
      fetch_ok_ff <= in_blocking_region(fetch_addr) ||
                     !(region_busy_ff || flash_erase || flash_write);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_ff <= `FS_BOOT_2048;
    end else begin
      case ({boot_size_fuse_hi, boot_size_fuse_lo})
        2'h3:    boot_ff <= `FS_BOOT_256;
        2'h2:    boot_ff <= `FS_BOOT_512;
        2'h1:    boot_ff <= `FS_BOOT_1024;
        default: boot_ff <= `FS_BOOT_2048;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    buf_rd_ff <= filled_ff[buf_rd_index] ? buf_ff[buf_rd_index] : 16'hFFFF;
  end

  assign s_axi_awready   = awready_ff;
  assign s_axi_wready    = wready_ff;
  assign s_axi_bvalid    = bvalid_ff;
  assign s_axi_bresp     = bresp_ff;
  assign s_axi_arready   = arready_ff;
  assign s_axi_rvalid    = rvalid_ff;
  assign s_axi_rdata     = rdata_ff;
  assign s_axi_rresp     = rresp_ff;
  assign fetch_allowed   = fetch_ok_ff;
  assign cpu_halt        = halt_ff;
  assign boot_start_addr = boot_ff;
  assign flash_erase     = (st_ff == ST_BUSY) && (cmd_ff == CMD_ERASE);
  assign flash_write     = (st_ff == ST_BUSY) && (cmd_ff == CMD_WRITE);
  assign flash_page      = page_ff;
  assign buf_rd_data     = buf_rd_ff;
  assign lock_bits       = lock_ff;
endmodule // flash_self_program_sequencer

/* File: tb/cpu_store_model.sv */
`timescale 1ns/1ps
module cpu_store_model (
  input  wire logic        aclk,
  input  wire logic        go,
  input  wire logic [13:0] word_addr,
  input  wire logic [15:0] data_in,
  output logic             store_strobe,
  output logic [15:0]      z_pointer,
  output logic [15:0]      store_data
);
  initial begin
    store_strobe = 1'b0;
    z_pointer    = 16'h0000;
    store_data   = 16'h0000;
  end
  // one store instruction per request; the byte select stays clear
  always @(posedge aclk) begin
    store_strobe <= go;
    if (go) begin
      z_pointer  <= {1'b0, word_addr, 1'b0};
      store_data <= data_in;
    end else if (store_strobe) begin
      // operands are gone after the store, so stale values must not match
      z_pointer  <= ~z_pointer;
      store_data <= ~store_data;
    end
  end
endmodule // cpu_store_model

/* File: tb/flash_seq_checker.sv */
`timescale 1ns/1ps
module flash_seq_checker #(
  parameter int TICK_DIV = 2,
  parameter int OP_TICKS = 5
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        supply_good,
  input wire logic        boot_size_fuse_hi,
  input wire logic        boot_size_fuse_lo,
  input wire logic        store_strobe,
  input wire logic [15:0] z_pointer,
  input wire logic [13:0] fetch_addr,
  input wire logic        fetch_allowed,
  input wire logic        cpu_halt,
  input wire logic [13:0] boot_start_addr,
  input wire logic        flash_erase,
  input wire logic        flash_write,
  input wire logic [7:0]  flash_page
);
  localparam int OPC = TICK_DIV * OP_TICKS;
  logic        busy;
  logic [13:0] boot_exp;
  logic [31:0] cnt_ff;
  logic [7:0]  zpage_ff;
  assign busy = flash_erase | flash_write;
  assign boot_exp = 14'h0 - (14'h0100 << ~{boot_size_fuse_hi, boot_size_fuse_lo});
  // the busy count follows the engine, which only power loss resets while an operation runs
  always_ff @(posedge aclk) begin
    if (!supply_good) cnt_ff <= 32'h0;
    else cnt_ff <= busy ? cnt_ff + 32'h1 : 32'h0;
  end
  always_ff @(posedge aclk) begin
    if (store_strobe) zpage_ff <= z_pointer[14:7];
  end
  //////////////////////////////////////////////////////////////////////////////
  a_boot_region: assert property (@(posedge aclk) disable iff (!aresetn || !supply_good)
    $past(aresetn) && $past(supply_good) |-> boot_start_addr == $past(boot_exp))
    else $error("boot start does not follow fuses");
  a_busy_min: assert property (@(posedge aclk) disable iff (!supply_good)
    $fell(busy) |-> cnt_ff >= OPC) else $error("operation ended early");
  a_busy_max: assert property (@(posedge aclk) disable iff (!supply_good)
    busy |-> cnt_ff < OPC + 3) else $error("operation overran");
  a_reset_keeps_op: assert property (@(posedge aclk) disable iff (!supply_good)
    !$past(aresetn) && $past(busy) && $past(cnt_ff) < OPC - 1 |-> busy)
    else $error("reset aborted operation");
  a_page_sel: assert property (@(posedge aclk) disable iff (!supply_good)
    $rose(busy) |-> flash_page == zpage_ff) else $error("page not from z");
  a_halt_block: assert property (@(posedge aclk) disable iff (!supply_good)
    busy && $past(busy) && flash_page >= 8'hE0 |-> cpu_halt) else $error("no halt");
  a_halt_conc: assert property (@(posedge aclk) disable iff (!supply_good)
    busy && $past(busy) && flash_page < 8'hE0 |-> !cpu_halt) else $error("bad halt");
  a_fetch_conc: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) && busy && $past(busy) && $past(fetch_addr) < 14'h3800
    |-> !fetch_allowed) else $error("fetch allowed during op");
  a_fetch_block: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) && $past(fetch_addr) >= 14'h3800 |-> fetch_allowed)
    else $error("blocking region fetch refused");
endmodule // flash_seq_checker
bind flash_self_program_sequencer flash_seq_checker #(
  .TICK_DIV(TICK_DIV), .OP_TICKS(OP_TICKS)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .supply_good(supply_good), .boot_size_fuse_hi(boot_size_fuse_hi),
  .boot_size_fuse_lo(boot_size_fuse_lo), .store_strobe(store_strobe),
  .z_pointer(z_pointer), .fetch_addr(fetch_addr), .fetch_allowed(fetch_allowed),
  .cpu_halt(cpu_halt), .boot_start_addr(boot_start_addr), .flash_erase(flash_erase),
  .flash_write(flash_write), .flash_page(flash_page));

/* File: tb/test_flash_self_program_sequencer.sv */
`timescale 1ns/1ps
module test_flash_self_program_sequencer;
  logic        aclk, aresetn, supply_good, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, boot_size_fuse_hi, boot_size_fuse_lo, go;
  logic        eeprom_write_busy_bit, store_strobe, fetch_allowed, cpu_halt;
  logic        flash_erase, flash_write;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, flash_page;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [13:0] word_addr, fetch_addr, boot_start_addr;
  logic [15:0] z_pointer, store_data, data_in, buf_rd_data;
  logic [5:0]  buf_rd_index, lock_bits;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  r;
  int          err_count, n_tests;
  flash_self_program_sequencer #(.TICK_DIV(2), .OP_TICKS(5)) dut (.aclk, .aresetn,
    .supply_good, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .boot_size_fuse_hi, .boot_size_fuse_lo,
    .eeprom_write_busy_bit, .store_strobe, .z_pointer, .store_data, .fetch_addr,
    .fetch_allowed, .cpu_halt, .boot_start_addr, .flash_erase, .flash_write,
    .flash_page, .buf_rd_index, .buf_rd_data, .lock_bits);
  cpu_store_model cpu (.aclk, .go, .word_addr, .data_in, .store_strobe, .z_pointer,
    .store_data);
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic stall();
    err_count++;
    print_verdict();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // each bus task starts one edge late so a released strobe never re-rises in the same step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (k == 50) stall();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (k == 50) stall();
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic store(input logic [13:0] a, input logic [15:0] d, input int dly);
    tick(dly);
    word_addr <= a;
    data_in <= d;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
  endtask
  task automatic poll();
    int k;
    for (k = 0; k < 100; k++) begin
      rd(8'h00);
      if (v[0] === 1'b0 && eeprom_write_busy_bit === 1'b0) break;
    end
    if (k == 100) stall();
  endtask
  task automatic op(input logic [4:0] code, input logic [13:0] a, input logic [15:0] d);
    poll();
    wr(8'h00, {27'h0, code});
    check("ctrl_resp", r, 2'h0);
    store(a, d, 0);
    tick(3);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_boot();
    logic [13:0] bexp [4] = '{14'h3800, 14'h3C00, 14'h3E00, 14'h3F00};
    for (int f = 0; f < 4; f++) begin
      {boot_size_fuse_hi, boot_size_fuse_lo} <= f[1:0];
      rd(8'h08);
      tick(2);
      check("boot_reg", v, {18'h0, bexp[f]});
      check("boot_pin", boot_start_addr, bexp[f]);
    end
    rd(8'h10);
    check("unmapped_resp", r, 2'h2);
    wr(8'h08, 32'h0000_0000);
    check("ro_write_resp", r, 2'h2);
  endtask
  task automatic t_concurrent();
    op(5'h01, 14'h0405, 16'hA5C3);
    buf_rd_index <= 6'h05;
    tick(2);
    check("buf_word", buf_rd_data, 16'hA5C3);
    buf_rd_index <= 6'h06;
    tick(2);
    check("buf_empty", buf_rd_data, 16'hFFFF);
    fetch_addr <= 14'h0100;
    op(5'h03, 14'h0400, 16'h0000);
    check("erase_busy", flash_erase, 1'b1);
    check("erase_page", flash_page, 8'h10);
    check("fetch_conc", fetch_allowed, 1'b0);
    rd(8'h04);
    check("stat_busy", v, 32'h0000_0007);
    op(5'h05, 14'h0400, 16'h0000);
    check("write_busy", flash_write, 1'b1);
    poll();
    check("flag_set", v[6], 1'b1);
    check("fetch_flag", fetch_allowed, 1'b0);
    op(5'h11, 14'h0000, 16'h0000);
    rd(8'h00);
    check("flag_clear", v[6], 1'b0);
    check("fetch_back", fetch_allowed, 1'b1);
  endtask
  task automatic t_blocking();
    fetch_addr <= 14'h3A00;
    op(5'h03, 14'h3945, 16'h0000);
    check("block_page", flash_page, 8'hE5);
    check("halt", cpu_halt, 1'b1);
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    tick(1);
    check("op_survives", flash_erase, 1'b1);
  endtask
  task automatic t_arm();
    poll();
    wr(8'h00, 32'h0000_0003);
    // strobe lands on the first edge after the four-cycle arm window
    store(14'h0400, 16'h0000, 2);
    tick(3);
    check("late_store", flash_erase, 1'b0);
    rd(8'h00);
    check("arm_clear", v[4:0], 5'h00);
    eeprom_write_busy_bit <= 1'b1;
    wr(8'h00, 32'h0000_0003);
    store(14'h0400, 16'h0000, 0);
    tick(3);
    check("ee_block", flash_erase, 1'b0);
    eeprom_write_busy_bit <= 1'b0;
    op(5'h09, 14'h0001, 16'h00F0);
    poll();
    check("lock_bits", lock_bits, 6'h30);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    {aresetn, supply_good, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, go, eeprom_write_busy_bit} = 4'h0;
    {boot_size_fuse_hi, boot_size_fuse_lo} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    {word_addr, data_in, buf_rd_index} = 36'h0;
    fetch_addr = 14'h3A00;
    err_count = 0;
    n_tests = 0;
    tick(1);
    supply_good <= 1'b1;
    tick(4);
    aresetn <= 1'b1;
    rd(8'h0C);
    check("lock_reset", v, 32'h0000_003F);
    t_boot();
    t_concurrent();
    t_blocking();
    t_arm();
    print_verdict();
  end
endmodule // test_flash_self_program_sequencer
